/* rtl/rssq_pkg.sv */
`default_nettype none
package rssq_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS  = 50;
    localparam int INIT_DELAY_NS  = 1100000;
    localparam int INIT_DELAY_CYC =
        (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_NS        = 93000;
    localparam int HOLD_CYC       = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GOOD_NS        = 93000;
    localparam int GOOD_CYC       = (GOOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W          = 16;

    // ************************************************************
    // Reference levels, counted in 6.25 mV steps
    // ************************************************************
    localparam int           LVL_W      = 9;
    localparam logic [8:0]   LVL_ZERO   = 9'h000;
    localparam logic [8:0]   BOOT_LEVEL = 9'h0b0;
    localparam logic [8:0]   VID8_TOP   = 9'h102;
    localparam logic [7:0]   VID8_FIRST = 8'h02;
    localparam logic [8:0]   VID6_TOP   = 9'h0f8;
    localparam logic [8:0]   VID5_TOP   = 9'h0e8;
    localparam logic [4:0]   NO_LOAD5   = 5'h1f;

    typedef enum logic [1:0] {
        MODE_VID8 = 2'h0,
        MODE_VID6 = 2'h1,
        MODE_VID5 = 2'h2
    } rssq_mode_t;

    // Gray codes along the eight-bit start-up path.
    typedef enum logic [2:0] {
        ST_SHUT       = 3'h0,
        ST_DELAY      = 3'h1,
        ST_RAMP_BOOT  = 3'h3,
        ST_HOLD       = 3'h2,
        ST_RAMP_FINAL = 3'h6,
        ST_GOOD_WAIT  = 3'h7,
        ST_DONE       = 3'h5
    } rssq_state_t;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  REG_STEP_DIV = 5'h00;
    localparam logic [4:0]  REG_MODE     = 5'h04;
    localparam logic [4:0]  REG_STATUS   = 5'h08;
    localparam logic [4:0]  REG_LEVEL    = 5'h0c;
    localparam logic [15:0] STEP_DIV_RST = 16'h0064;
    localparam int          ST_POWER_GOOD_OUT_BIT = 3;
    localparam int          ST_DRIVE_BIT = 4;
    localparam int          ST_START_BIT = 5;
    localparam int          LVL_TGT_LSB  = 16;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Turns a code into {valid, level}; the all-off codes are invalid.
    function automatic logic [9:0] vid_decode(input logic [7:0] code,
                                              input rssq_mode_t mode);
        logic [9:0] res;
        res = 10'h000;
        case (mode)
            MODE_VID8: begin
                res = {(code >= VID8_FIRST),
                       9'(VID8_TOP - 9'(code - VID8_FIRST))};
            end
            MODE_VID6: begin
                res = {1'b1, 9'(VID6_TOP - {2'h0, code[5:0], 1'b0})};
            end
            MODE_VID5: begin
                res = {(code[4:0] != NO_LOAD5),
                       9'(VID5_TOP - {2'h0, code[4:0], 2'h0})};
            end
            default: begin
                res = 10'h000;
            end
        endcase
        return res;
    endfunction

endpackage
`default_nettype wire

/* rtl/rssq_step_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module rssq_step_tick (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             tick
);

    logic [15:0] cnt_reg;

    // One-cycle enable every period cycles while run is high; a zero
    // period behaves as one so the ramp can never stall.
    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_reg <= 16'h0000;
            tick    <= 1'b0;
        end else if (cnt_reg + 16'h0001 >= period) begin
            cnt_reg <= 16'h0000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick    <= 1'b0;
        end
    end

endmodule // rssq_step_tick
`default_nettype wire

/* rtl/rssq_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
module rssq_sequencer
    import rssq_pkg::*;
#(
    parameter int INIT_DELAY_CYCLES = INIT_DELAY_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [4:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [4:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        logic_por_ok,
    input  wire logic        enable_above,
    input  wire logic        driver_bias_supply_ok,
    input  wire logic [7:0]  voltage_id_code,
    input  wire logic        feedback_input_above,
    input  wire logic        remote_sense_in_window,
    input  wire logic [1:0]  pwm_demand,
    output logic [1:0]       high_side_gate_drive,
    output logic [1:0]       low_side_gate_drive,
    output logic             power_good_out,
    output logic [8:0]       reference_level
);

    // ************************************************************
    // Declarations
    // ************************************************************
    rssq_state_t   state_reg;
    rssq_mode_t    mode_reg;
    logic [15:0]   timer_reg;
    logic [15:0]   step_div_reg;
    logic [8:0]    target_reg;
    logic          drive_en_reg;
    logic          start_ok;
    logic          start_go;
    logic          step_tick;
    logic          ramping;
    logic [9:0]    vid_now;
    logic          aw_got_reg;
    logic          w_got_reg;
    logic [4:0]    awaddr_reg;
    logic [31:0]   wdata_reg;
    logic [3:0]    wstrb_reg;
    logic [8:0]    ref_out_reg_q;

    // The reference output is the stepping register itself.
    assign reference_level = ref_out_reg_q;

    localparam logic [15:0] INIT_LAST = 16'(INIT_DELAY_CYCLES - 1);
    localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYC - 1);
    localparam logic [15:0] GOOD_LAST = 16'(GOOD_CYC - 1);

    // One step of the reference toward its goal.
    function automatic logic [8:0] step_toward(input logic [8:0] cur,
                                               input logic [8:0] goal);
        logic [8:0] res;
        res = cur;
        if (cur < goal) begin
            res = cur + 9'h001;
        end else if (cur > goal) begin
            res = cur - 9'h001;
        end
        return res;
    endfunction

    // ************************************************************
    // Start conditions
    // ************************************************************
    // All three must hold; the no-load code only blocks the start itself.
    assign start_ok = logic_por_ok && enable_above
                      && driver_bias_supply_ok;
    assign start_go = start_ok && !(mode_reg == MODE_VID5
                      && voltage_id_code[4:0] == NO_LOAD5);
    assign vid_now  = vid_decode(voltage_id_code, mode_reg);
    assign ramping  = (state_reg == ST_RAMP_BOOT)
                      || (state_reg == ST_RAMP_FINAL);

    // The rate resistor is modelled by the step divider register.
    rssq_step_tick u_step_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (ramping),
        .period  (step_div_reg),
        .tick    (step_tick)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Any lost condition wins over every other transition.
    always_ff @(posedge aclk) begin
        if (!aresetn || !start_ok) begin
            state_reg <= ST_SHUT;
            timer_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_SHUT: begin
                    timer_reg <= 16'h0000;
                    if (start_go) begin
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    timer_reg <= timer_reg + 16'h0001;
                    if (timer_reg >= INIT_LAST) begin
                        timer_reg <= 16'h0000;
                        state_reg <= (mode_reg == MODE_VID8) ? ST_RAMP_BOOT
                                     : ST_RAMP_FINAL;
                    end
                end
                ST_RAMP_BOOT: begin
                    if (ref_out_reg_q == BOOT_LEVEL) begin
                        state_reg <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    timer_reg <= timer_reg + 16'h0001;
                    // An invalid code keeps the boot level and retries.
                    if (timer_reg >= HOLD_LAST) begin
                        timer_reg <= 16'h0000;
                        if (vid_now[9]) begin
                            state_reg <= ST_RAMP_FINAL;
                        end
                    end
                end
                ST_RAMP_FINAL: begin
                    if (ref_out_reg_q == target_reg) begin
                        state_reg <= (mode_reg == MODE_VID8) ? ST_GOOD_WAIT
                                     : ST_DONE;
                    end
                end
                ST_GOOD_WAIT: begin
                    timer_reg <= timer_reg + 16'h0001;
                    if (timer_reg >= GOOD_LAST) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    timer_reg <= 16'h0000;
                end
                default: begin
                    state_reg <= ST_SHUT;
                    timer_reg <= 16'h0000;
                end
            endcase
        end
    end

    // Final level: captured at start in the short modes, after the hold
    // in eight-bit mode.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            target_reg <= LVL_ZERO;
        end else if (state_reg == ST_SHUT && start_go
                     && mode_reg != MODE_VID8) begin
            target_reg <= vid_now[8:0];
        end else if (state_reg == ST_HOLD && timer_reg >= HOLD_LAST
                     && vid_now[9]) begin
            target_reg <= vid_now[8:0];
        end
    end

    // Reference ramps only on a step tick, one step at a time; shutdown or a lost condition clears it at once.
    always_ff @(posedge aclk) begin
        if (!aresetn || !start_ok || state_reg == ST_SHUT
            || state_reg == ST_DELAY) begin
            ref_out_reg_q <= LVL_ZERO;
        end else if (step_tick && state_reg == ST_RAMP_BOOT) begin
            ref_out_reg_q <= step_toward(ref_out_reg_q, BOOT_LEVEL);
        end else if (step_tick && state_reg == ST_RAMP_FINAL) begin
            ref_out_reg_q <= step_toward(ref_out_reg_q, target_reg);
        end
    end

    // ************************************************************
    // Gate drive and power-good
    // ************************************************************
    // Drivers stay off while feedback sits above the reference and are
    // released for good once the reference passes it or the ramp ends.
    always_ff @(posedge aclk) begin
        if (!aresetn || !start_ok || state_reg == ST_SHUT
            || state_reg == ST_DELAY) begin
            drive_en_reg <= 1'b0;
        end else if (ramping && !feedback_input_above) begin
            drive_en_reg <= 1'b1;
        end else if (state_reg == ST_GOOD_WAIT || state_reg == ST_DONE) begin
            drive_en_reg <= 1'b1;
        end
    end

    // Both gates low when disabled, else complementary per phase.
    always_ff @(posedge aclk) begin
        if (!aresetn || state_reg == ST_SHUT || !drive_en_reg) begin
            high_side_gate_drive <= 2'h0;
            low_side_gate_drive  <= 2'h0;
        end else begin
            high_side_gate_drive <= pwm_demand;
            low_side_gate_drive  <= ~pwm_demand;
        end
    end

    always_ff @(posedge aclk) begin
        // A lost start condition drops power-good at the same edge as
        // the return to shutdown, not one cycle later.
        if (!aresetn || !start_ok || state_reg != ST_DONE) begin
            power_good_out <= 1'b0;
        end else if (mode_reg == MODE_VID8) begin
            power_good_out <= 1'b1;
        end else begin
            power_good_out <= remote_sense_in_window;
        end
    end

    // ************************************************************
    // AXI4-Lite slave
    // ************************************************************
    // Address and data are taken in either order; the write lands once
    // both are in, and readies stay low until the response is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            awaddr_reg    <= 5'h00;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg    <= 1'b1;
                s_axi_awready <= 1'b0;
                awaddr_reg    <= s_axi_awaddr;
            end else if (!aw_got_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg    <= 1'b1;
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end else if (!w_got_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg[4:2] <= REG_LEVEL[4:2])
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable settings, honouring byte strobes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_div_reg <= STEP_DIV_RST;
            mode_reg     <= MODE_VID8;
        end else if (aw_got_reg && w_got_reg && !s_axi_bvalid) begin
            if (awaddr_reg == REG_STEP_DIV) begin
                if (wstrb_reg[0]) step_div_reg[7:0]  <= wdata_reg[7:0];
                if (wstrb_reg[1]) step_div_reg[15:8] <= wdata_reg[15:8];
            end
            // Mode should only change in shutdown; a live change takes
            // effect at the next decision point.
            if (awaddr_reg == REG_MODE && wstrb_reg[0]) begin
                mode_reg <= (wdata_reg[1:0] == 2'h3) ? MODE_VID8
                            : rssq_mode_t'(wdata_reg[1:0]);
            end
        end
    end

    // Reads answer one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
                REG_STEP_DIV: s_axi_rdata <= {16'h0000, step_div_reg};
                REG_MODE:     s_axi_rdata <= {30'h00000000, mode_reg};
                REG_STATUS: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rdata[2:0]          <= state_reg;
                    s_axi_rdata[ST_POWER_GOOD_OUT_BIT] <= power_good_out;
                    s_axi_rdata[ST_DRIVE_BIT] <= drive_en_reg;
                    s_axi_rdata[ST_START_BIT] <= start_ok;
                end
                REG_LEVEL: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rdata[8:0] <= ref_out_reg_q;
                    s_axi_rdata[LVL_TGT_LSB +: 9] <= target_reg;
                end
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_shut_gates_off: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_SHUT |=> high_side_gate_drive == 2'h0
        && low_side_gate_drive == 2'h0)
        else $error("gates driven in shutdown");
    a_lost_cond_shut: assert property (@(posedge aclk) disable iff (!aresetn)
        !start_ok |=> state_reg == ST_SHUT && !power_good_out)
        else $error("start condition lost but not shut down");
    a_no_load_block: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_SHUT && mode_reg == MODE_VID5
        && voltage_id_code[4:0] == NO_LOAD5 |=> state_reg == ST_SHUT)
        else $error("start with no-load code");
    a_start_now: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_SHUT && start_go |=> state_reg == ST_DELAY)
        else $error("start not immediate");
    a_delay_ref_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        state_reg == ST_DELAY |-> ref_out_reg_q == LVL_ZERO
        && timer_reg <= INIT_LAST)
        else $error("reference moved during initial delay");
    a_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
        ramping && $past(ramping) && !$past(step_tick)
        |-> $stable(ref_out_reg_q))
        else $error("reference moved without a step tick");
    a_boot_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(state_reg == ST_HOLD) |-> ref_out_reg_q == BOOT_LEVEL
        ##1 (state_reg == ST_HOLD) [*8])
        else $error("boot hold too short or wrong level");
    a_power_good_out_done: assert property (@(posedge aclk) disable iff (!aresetn)
        power_good_out |-> $past(state_reg == ST_DONE))
        else $error("power-good before soft-start end");
    a_prebias_off: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(ramping) && feedback_input_above
        |=> !drive_en_reg)
        else $error("drivers on while pre-biased");

endmodule // rssq_sequencer
`default_nettype wire

/* rtl/rssq_fix_note.sv */
`default_nettype none
`default_nettype wire

/* bench/rssq_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Processor side of the code lines
// ****************************************
module rssq_cpu_model (
    input  wire logic       aclk,
    input  wire logic [7:0] want,
    output logic [7:0]      voltage_id_code
);
    logic [3:0] settle_reg = 4'h0;
    // A new code appears only after 16 cycles, far inside the hold window.
    always @(posedge aclk) begin
        if (want !== voltage_id_code) begin
            settle_reg <= settle_reg + 4'h1;
            if (settle_reg == 4'hf) voltage_id_code <= want;
        end else begin
            settle_reg <= 4'h0;
        end
    end
endmodule // rssq_cpu_model
`default_nettype wire

/* bench/regulator_soft_start_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_soft_start_sequencer_bench;
    import rssq_pkg::*;
    logic aclk = 0, aresetn = 0, feedback_input_above = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, remote_sense_in_window = 0;
    logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, power_good_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, high_side_gate_drive;
    logic [1:0] low_side_gate_drive, pwm_demand = 0;
    logic [2:0] sup = 0;
    logic [7:0] want = 8'h00, voltage_id_code, c;
    logic [8:0] reference_level;
    int mismatches = 0, total_checks = 0, n;
    wire logic_por_ok = sup[2];
    wire enable_above = sup[1];
    wire driver_bias_supply_ok = sup[0];
    rssq_sequencer #(.INIT_DELAY_CYCLES(20)) u_rssq_sequencer (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .logic_por_ok(logic_por_ok),
        .enable_above(enable_above),
        .driver_bias_supply_ok(driver_bias_supply_ok),
        .voltage_id_code(voltage_id_code),
        .feedback_input_above(feedback_input_above),
        .remote_sense_in_window(remote_sense_in_window),
        .pwm_demand(pwm_demand),
        .high_side_gate_drive(high_side_gate_drive),
        .low_side_gate_drive(low_side_gate_drive),
        .power_good_out(power_good_out),
        .reference_level(reference_level)
    );
    rssq_cpu_model u_rssq_cpu_model (
        .aclk(aclk), .want(want), .voltage_id_code(voltage_id_code)
    );
    // Free-running 20 MHz clock.
    initial begin
        forever #25 aclk = ~aclk;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    // Every wait is bounded; running out ends the run.
    task automatic tmo(input int k);
        if (k >= 20000) begin
            mismatches++;
            $display("unexpected at %0t: wait ran out", $time);
            wrap_up();
        end
    endtask
    task automatic wt(input logic [8:0] l, input logic p, output int k);
        k = 0;
        while (!(reference_level === l && power_good_out === p) && k < 20000)
        begin
            @(posedge aclk);
            k++;
        end
        tmo(k);
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            k++;
        end while (!s_axi_bvalid && k < 20000);
        tmo(k);
        s_axi_bready <= 0;
        chk(32'(s_axi_bresp), 32'(RESP_OKAY));
    endtask
    task automatic axr(input logic [4:0] a);
        int k = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            k++;
        end while (!s_axi_rvalid && k < 20000);
        tmo(k);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hb94c4d89));
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 3; i++) begin
            sup <= 3'h7 ^ (3'h1 << i);
            repeat (40) @(posedge aclk);
            chk(32'({reference_level, high_side_gate_drive, low_side_gate_drive,
                power_good_out}), 0);
        end
        $display("test shutdown done");
        axw(REG_STEP_DIV, 32'h2);
        axr(REG_STEP_DIV);
        chk(rd, 32'h2);
        axr(5'h10);
        chk(32'(rs), 32'(RESP_SLVERR));
        $display("test registers done");
        c = 8'($urandom_range(255, 2));
        if (c == 8'd84) c = 8'd85; // Keeps the final level off the boot level.
        want <= c;
        pwm_demand <= 2'($urandom);
        axw(REG_MODE, 32'(MODE_VID8));
        sup <= 3'h7;
        repeat (10) @(posedge aclk);
        chk(32'(reference_level), 0);
        wt(BOOT_LEVEL, 0, n);
        chk(32'(n inside {[340:400]}), 1);
        wt(9'(VID8_TOP - c + VID8_FIRST), 0, n);
        chk(32'(n >= HOLD_CYC), 1);
        wt(9'(VID8_TOP - c + VID8_FIRST), 1, n);
        chk(32'(n >= GOOD_CYC), 1);
        sup <= 3'h5;
        repeat (4) @(posedge aclk);
        chk(32'({reference_level, high_side_gate_drive, low_side_gate_drive,
            power_good_out}), 0);
        $display("test eight-bit done");
        want <= 8'h1f;
        repeat (20) @(posedge aclk);
        axw(REG_MODE, 32'(MODE_VID5));
        sup <= 3'h7;
        repeat (60) @(posedge aclk);
        chk(32'(reference_level), 0);
        c = 8'($urandom_range(30, 0));
        want <= c;
        remote_sense_in_window <= 1'($urandom);
        wt(9'(VID5_TOP - 9'(c) * 4), remote_sense_in_window,
           n);
        sup <= 3'h0;
        $display("test five-bit done");
        want <= 8'($urandom_range(63, 0));
        feedback_input_above <= 1;
        repeat (20) @(posedge aclk);
        axw(REG_MODE, 32'(MODE_VID6));
        sup <= 3'h7;
        wt(9'd50, 0, n);
        chk(32'({high_side_gate_drive, low_side_gate_drive}), 0);
        feedback_input_above <= 0;
        repeat (4) @(posedge aclk);
        chk(32'({high_side_gate_drive, low_side_gate_drive}),
            32'({pwm_demand, ~pwm_demand}));
        $display("test pre-bias done");
        wrap_up();
    end
endmodule // regulator_soft_start_sequencer_bench
`default_nettype wire
